// ---- verilog/fsp_pkg.sv ----
// package for the flash status poller: pins, timing, command codes
package fsp_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned ADDR_W = 17;
  localparam int unsigned DATA_W = 8;
  // status bit positions on the data bus
  localparam int unsigned POLL_BIT_POS = 7;
  localparam int unsigned DEV_TOGGLE_POS = 6;
  localparam int unsigned TIMING_FAIL_POS = 5;
  localparam int unsigned ERASE_WIN_POS = 3;
  localparam int unsigned SEC_TOGGLE_POS = 2;
  // bus cycle timing: strobe low time and gap, in ns
  localparam int unsigned STROBE_NS = 120;
  localparam int unsigned GAP_NS = 80;
  localparam int unsigned STROBE_CYC = (STROBE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned GAP_CYC = (GAP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  // host guarantee on spacing of extra sector-erase commands
  localparam int unsigned ERASE_GAP_US = 50;
  localparam int unsigned ERASE_GAP_CYC = ERASE_GAP_US * (CLK_HZ / 1000000);
  localparam logic [7:0] RESET_CMD = 8'hF0;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 17'h00000;
  localparam logic [3:0] CNT_RST = 4'h0;

  // outcome of one poll job
  typedef enum logic [2:0] {
    RES_NONE = 3'h0,
    RES_DONE = 3'h1,
    RES_FAIL = 3'h2,
    RES_SUSP = 3'h3
  } fsp_result_t;

  // flash pin group
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
  } fsp_pins_t;

  // status snapshot taken from one read
  typedef struct packed {
    logic poll_status_bit;
    logic device_toggle_bit;
    logic timing_failure_flag;
    logic erase_window_bit;
    logic sector_toggle_bit;
  } fsp_stat_t;
endpackage

// ---- verilog/fsp_cycle.sv ----
// one framed flash bus cycle, read or write
module fsp_cycle
  import fsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic is_write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] dq_sync,
  output logic busy,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output fsp_pins_t pins,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n
);
  typedef enum logic [2:0] {
    C_IDLE = 3'b001,
    C_STRB = 3'b010,
    C_GAP = 3'b100
  } fsp_cyc_t;
  fsp_cyc_t st_q;
  logic [3:0] cnt_q;
  logic wr_q;

  // sequence strobe then recovery gap; sample data two cycles late via sync
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      st_q <= C_IDLE;
      cnt_q <= CNT_RST;
      wr_q <= 1'b0;
      pins <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: '0};
      dq_out <= '0;
      dq_oe_n <= 1'b1;
      rdata <= '0;
    end else begin
      case (st_q)
        C_IDLE: begin
          if (start) begin
            wr_q <= is_write;
            pins <= '{ce_n: 1'b0, oe_n: is_write, we_n: !is_write, addr: addr};
            dq_out <= wdata;
            dq_oe_n <= !is_write;
            cnt_q <= 4'(STROBE_CYC + 2);
            st_q <= C_STRB;
          end
        end
        C_STRB: begin
          if (cnt_q == 4'h0) begin
            if (!wr_q)
              rdata <= dq_sync; // synchroniser delay covered by +2
            pins.ce_n <= 1'b1;
            pins.oe_n <= 1'b1;
            pins.we_n <= 1'b1; // read/write completes on strobe rise
            cnt_q <= 4'(GAP_CYC);
            st_q <= C_GAP;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        C_GAP: begin
          dq_oe_n <= 1'b1;
          if (cnt_q == 4'h0) begin
            done <= 1'b1;
            st_q <= C_IDLE;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        default: st_q <= C_IDLE;
      endcase
    end
  end
  assign busy = (st_q != C_IDLE);
endmodule

// ---- verilog/fsp_poller.sv ----
// host-side controller polling flash program/erase status over its pins
// Functional notes
// - host double-reads and compares toggle
// - toggling with failure flag: recheck, else reset
// - resumed polling restarts from double read
// - host writes reset after any failure
// - fast hosts may skip window monitoring
// - check window before and after extra erase; code only samples it on RD2 reads with WIN_CHECK high
// - host presents valid address for status
// - valid address depends on operation
// - recheck toggle bit after failure flag
module fsp_poller
  import fsp_pkg::*;
(
  input wire logic REF_CLK,
  input wire logic RESET,
  // user orders
  input wire logic START,
  input wire logic ABORT,
  input wire logic [ADDR_W-1:0] POLL_ADDR,
  input wire logic IS_PROGRAM,
  input wire logic [DATA_W-1:0] PROG_DATA,
  input wire logic WIN_CHECK,
  // user results
  output logic BUSY,
  output logic DONE,
  output fsp_result_t RESULT,
  output logic WIN_LATE,
  output fsp_stat_t LAST_STAT,
  // flash pins
  output logic CE_N,
  output logic OE_N,
  output logic WE_N,
  output logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] DQ_IN,
  output logic [DATA_W-1:0] DQ_OUT,
  output logic DQ_OE_N
);
  typedef enum logic [6:0] {
    S_IDLE = 7'b0000001,
    S_RD1 = 7'b0000010,
    S_RD2 = 7'b0000100,
    S_RD3 = 7'b0001000,
    S_RD4 = 7'b0010000,
    S_RST = 7'b0100000,
    S_FIN = 7'b1000000
  } fsp_state_t;

  fsp_state_t st_q;
  logic [DATA_W-1:0] dq_m_q, dq_s_q;
  logic cyc_start, cyc_write, cyc_busy, cyc_done;
  logic [DATA_W-1:0] cyc_rdata, first_q, cyc_dq, cyc_wdata;
  logic cyc_oe_n;
  fsp_pins_t cyc_pins;
  logic prog_q;
  logic [DATA_W-1:0] pdata_q;
  logic [ADDR_W-1:0] addr_q;
  logic launched_q;

  function automatic fsp_stat_t to_stat(input logic [DATA_W-1:0] d);
    to_stat = '{poll_status_bit: d[POLL_BIT_POS], device_toggle_bit: d[DEV_TOGGLE_POS],
                timing_failure_flag: d[TIMING_FAIL_POS], erase_window_bit: d[ERASE_WIN_POS],
                sector_toggle_bit: d[SEC_TOGGLE_POS]};
  endfunction

  // polling-bit completion: program expects true data bit, erase expects 1
  function automatic logic poll_done(input logic [DATA_W-1:0] d, input logic prog,
                                     input logic [DATA_W-1:0] want);
    poll_done = prog ? (d[POLL_BIT_POS] == want[POLL_BIT_POS]) : d[POLL_BIT_POS];
  endfunction

  // data pins come from another domain: two flops before use
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      dq_m_q <= '0;
      dq_s_q <= '0;
    end else begin
      dq_m_q <= DQ_IN;
      dq_s_q <= dq_m_q;
    end
  end

  fsp_cycle u_cycle (
    .clk(REF_CLK),
    .rst(RESET),
    .start(cyc_start),
    .is_write(cyc_write),
    .addr(cyc_write ? RESET_ADDR : addr_q),
    .wdata(cyc_wdata),
    .dq_sync(dq_s_q),
    .busy(cyc_busy),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .pins(cyc_pins),
    .dq_out(cyc_dq),
    .dq_oe_n(cyc_oe_n)
  );

  // launch a bus cycle on entering each state other than idle and finish, and again after each RD2 read that slides; reset state writes, others read
  assign cyc_write = (st_q == S_RST);
  assign cyc_wdata = RESET_CMD;
  assign cyc_start = !launched_q && !cyc_busy && (st_q != S_IDLE) && (st_q != S_FIN);

  // pins registered again so every output is a flop
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      CE_N <= 1'b1;
      OE_N <= 1'b1;
      WE_N <= 1'b1;
      ADDR <= '0;
      DQ_OUT <= '0;
      DQ_OE_N <= 1'b1;
    end else begin
      CE_N <= cyc_pins.ce_n;
      OE_N <= cyc_pins.oe_n;
      WE_N <= cyc_pins.we_n;
      ADDR <= cyc_pins.addr;
      DQ_OUT <= cyc_dq;
      DQ_OE_N <= cyc_oe_n;
    end
  end

  // toggle-polling sequencer
  always_ff @(posedge REF_CLK) begin
    DONE <= 1'b0;
    if (RESET) begin
      st_q <= S_IDLE;
      launched_q <= 1'b0;
      first_q <= '0;
      prog_q <= 1'b0;
      pdata_q <= '0;
      addr_q <= '0;
      BUSY <= 1'b0;
      RESULT <= RES_NONE;
      WIN_LATE <= 1'b0;
      LAST_STAT <= '0;
    end else begin
      if (cyc_start)
        launched_q <= 1'b1;
      case (st_q)
        S_IDLE: begin
          if (START) begin
            addr_q <= POLL_ADDR; // caller supplies valid status address
            prog_q <= IS_PROGRAM;
            pdata_q <= PROG_DATA;
            BUSY <= 1'b1;
            WIN_LATE <= 1'b0;
            launched_q <= 1'b0;
            st_q <= S_RD1; // every job starts with a fresh double read
          end
        end
        S_RD1: begin
          if (cyc_done) begin
            first_q <= cyc_rdata;
            LAST_STAT <= to_stat(cyc_rdata);
            launched_q <= 1'b0;
            st_q <= S_RD2;
          end
        end
        S_RD2: begin
          if (cyc_done) begin
            LAST_STAT <= to_stat(cyc_rdata);
            launched_q <= 1'b0;
            // fast hosts leave WIN_CHECK low and skip the window
            if (WIN_CHECK && cyc_rdata[ERASE_WIN_POS])
              WIN_LATE <= 1'b1; // extra erase may have been refused
            if (cyc_rdata[DEV_TOGGLE_POS] == first_q[DEV_TOGGLE_POS]) begin
              RESULT <= poll_done(cyc_rdata, prog_q, pdata_q) ? RES_DONE : RES_SUSP;
              st_q <= S_FIN;
            end else if (ABORT) begin
              RESULT <= RES_NONE; // caller left; next START restarts
              st_q <= S_FIN;
            end else if (cyc_rdata[TIMING_FAIL_POS]) begin
              first_q <= cyc_rdata;
              st_q <= S_RD3; // recheck toggle after failure flag
            end else begin
              first_q <= cyc_rdata; // slide: next read is compared with this one
            end
          end
        end
        S_RD3: begin
          if (cyc_done) begin
            first_q <= cyc_rdata;
            launched_q <= 1'b0;
            st_q <= S_RD4;
          end
        end
        S_RD4: begin
          if (cyc_done) begin
            LAST_STAT <= to_stat(cyc_rdata);
            launched_q <= 1'b0;
            if (cyc_rdata[DEV_TOGGLE_POS] == first_q[DEV_TOGGLE_POS]) begin
              RESULT <= RES_DONE; // stopped just as flag rose
              st_q <= S_FIN;
            end else begin
              RESULT <= RES_FAIL;
              st_q <= S_RST; // reset command after failure
            end
          end
        end
        S_RST: begin
          if (cyc_done) begin
            launched_q <= 1'b0;
            st_q <= S_FIN;
          end
        end
        S_FIN: begin
          BUSY <= 1'b0;
          DONE <= 1'b1;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // failure result always followed by the reset write
  a_fail_resets: assert property (@(posedge REF_CLK) disable iff (RESET)
    (st_q == S_RD4 && cyc_done && cyc_rdata[DEV_TOGGLE_POS] != first_q[DEV_TOGGLE_POS])
    |=> (st_q == S_RST && RESULT == RES_FAIL))
    else $error("failure not followed by reset write");
  // only the reset command state may strobe a write
  a_write_in_rst: assert property (@(posedge REF_CLK) disable iff (RESET)
    (!WE_N) |-> (st_q == S_RST))
    else $error("write strobe outside reset command state");
  // status address held steady through a read strobe
  a_addr_steady: assert property (@(posedge REF_CLK) disable iff (RESET)
    (!OE_N && $past(!OE_N)) |-> $stable(ADDR))
    else $error("address moved during read strobe");
  // reset write drives the reset command with data enabled
  a_reset_data: assert property (@(posedge REF_CLK) disable iff (RESET)
    (!WE_N) |-> (DQ_OUT == RESET_CMD && !DQ_OE_N))
    else $error("write strobe without reset command on data");
  // done pulse lasts one cycle and clears busy
  a_done_pulse: assert property (@(posedge REF_CLK) disable iff (RESET)
    DONE |-> (!BUSY ##1 !DONE))
    else $error("done pulse malformed");
  // reads never overlap writes on the pins
  a_no_contention: assert property (@(posedge REF_CLK) disable iff (RESET)
    (!OE_N) |-> (DQ_OE_N && WE_N))
    else $error("read strobe while driving data");
endmodule

// ---- dv/fsp_flash_model.sv ----
// behavioural flash device answering status reads during an embedded operation
module fsp_flash_model
  import fsp_pkg::*;
(
  // strobes
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  // operation set up by the bench
  input wire logic arm,
  input wire logic [7:0] cnt,
  input wire logic fail,
  input wire logic stuck,
  input wire logic win,
  input wire logic [DATA_W-1:0] data,
  // data bus toward the host
  output logic [DATA_W-1:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;
  int n_rd = 0;
  int n_wr = 0;
  int rd_base = 0;
  int wr_base = 0;
  int reads;
  logic active;
  logic tog;
  logic [DATA_W-1:0] stat;
  logic [DATA_W-1:0] last_q = 8'h00;
  wire rd_n = ce_n | oe_n;
  // a new operation counts reads and writes from here on
  always @(posedge arm) begin
    rd_base = n_rd;
    wr_base = n_wr;
  end
  // toggle state moves on at the end of each framed read, ce or oe framed
  always @(posedge rd_n) begin
    last_q = stat;
    n_rd++;
  end
  // any write is taken as the reset command, which returns the polling bit to true data; toggles run on to the read budget
  always @(posedge we_n) n_wr++;
  // status byte: toggles freeze once the read budget is spent
  always_comb begin
    reads = n_rd - rd_base;
    active = arm && (reads < cnt) && (n_wr == wr_base);
    tog = (reads < cnt) ? reads[0] : cnt[0];
    stat = data;
    stat[POLL_BIT_POS] = (active || stuck) ? ~data[POLL_BIT_POS] : data[POLL_BIT_POS];
    stat[DEV_TOGGLE_POS] = tog;
    stat[TIMING_FAIL_POS] = fail;
    stat[ERASE_WIN_POS] = win;
    stat[SEC_TOGGLE_POS] = tog;
  end
  // a released bus shows the inverse of the last value, never a stale copy
  assign dq = (rd_n == 1'b0) ? stat : ~last_q;
endmodule

// ---- dv/testbench.sv ----
// self-checking bench for the flash status poller
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; $display("wrong value at %0t: got %0h exp %0h", $time, a, b); end end
module testbench
  import fsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK = 1'b0;
  logic RESET = 1'b1;
  logic START = 1'b0;
  logic ABORT = 1'b0;
  logic IS_PROGRAM = 1'b0;
  logic WIN_CHECK = 1'b0;
  logic [ADDR_W-1:0] POLL_ADDR = 17'h00000;
  logic [ADDR_W-1:0] exp_addr = 17'h00000;
  logic [DATA_W-1:0] PROG_DATA = 8'h00;
  logic BUSY, DONE, WIN_LATE, CE_N, OE_N, WE_N, DQ_OE_N;
  fsp_result_t RESULT;
  fsp_stat_t LAST_STAT;
  logic [ADDR_W-1:0] ADDR;
  logic [DATA_W-1:0] DQ_OUT, dev_dq, bus, mdata;
  logic arm = 1'b0;
  logic fail = 1'b0;
  logic stuck = 1'b0;
  logic win = 1'b0;
  logic wc = 1'b0;
  logic [7:0] cnt = 8'h00;
  int n_errors = 0;
  int checked = 0;
  int n_rd = 0;
  int n_wr = 0;

  fsp_poller u_fsp_poller (.REF_CLK(REF_CLK), .RESET(RESET), .START(START), .ABORT(ABORT),
    .POLL_ADDR(POLL_ADDR), .IS_PROGRAM(IS_PROGRAM), .PROG_DATA(PROG_DATA), .WIN_CHECK(WIN_CHECK),
    .BUSY(BUSY), .DONE(DONE), .RESULT(RESULT), .WIN_LATE(WIN_LATE), .LAST_STAT(LAST_STAT),
    .CE_N(CE_N), .OE_N(OE_N), .WE_N(WE_N), .ADDR(ADDR), .DQ_IN(bus), .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N));
  fsp_flash_model u_fsp_flash_model (.ce_n(CE_N), .oe_n(OE_N), .we_n(WE_N), .arm(arm), .cnt(cnt),
    .fail(fail), .stuck(stuck), .win(win), .data(mdata), .dq(dev_dq));
  // erase completes with ones, so the model's final byte depends on the job kind
  assign mdata = {IS_PROGRAM ? PROG_DATA[7] : 1'b1, PROG_DATA[6:0]};
  assign bus = DQ_OE_N ? dev_dq : DQ_OUT;

  initial begin
    forever #20 REF_CLK = ~REF_CLK;
  end
  // every status read carries the job's own address, even after a refused start
  always @(negedge OE_N) n_rd++;
  // address compared mid-strobe, once it has settled together with the strobe
  always @(negedge REF_CLK) if (OE_N === 1'b0) `CHK(ADDR, exp_addr)
  always @(negedge WE_N) n_wr++;
  // the only write allowed is the reset command
  always @(negedge REF_CLK) if (WE_N === 1'b0) `CHK({DQ_OE_N, ADDR, DQ_OUT}, {1'b0, RESET_ADDR, RESET_CMD})

  // reads and verdict of one job, worked out from the polling procedure
  function automatic void predict(input int n, input logic f, s, ab, output fsp_result_t r, output int rd, wr);
    wr = 0;
    rd = n + 2; // each read is compared with the one before; stop at the first equal two
    r = s ? RES_SUSP : RES_DONE;
    if (n > 0 && ab) begin
      rd = 2;
      r = RES_NONE;
    end else if (n > 0 && f) begin
      rd = 4;
      wr = (n > 2);
      r = (n > 2) ? RES_FAIL : RES_DONE;
    end
  endfunction

  task automatic job(input int n, input logic f, s, ab, w);
    fsp_result_t r;
    int rd, wr, i;
    predict(n, f, s, ab, r, rd, wr);
    n_rd = 0;
    n_wr = 0;
    wc = 1'($urandom);
    exp_addr = 17'($urandom);
    @(posedge REF_CLK);
    {cnt, fail, stuck, win, arm, ABORT, WIN_CHECK} <= {n[7:0], f, s, w, 1'b1, ab, wc};
    {POLL_ADDR, PROG_DATA, IS_PROGRAM, START} <= {exp_addr, 8'($urandom), ~w & 1'($urandom), 1'b1};
    @(posedge REF_CLK);
    START <= 1'b0;
    @(negedge REF_CLK);
    `CHK(BUSY, 1'b1)
    // a second start while busy must be ignored
    @(posedge REF_CLK);
    {START, POLL_ADDR} <= {1'b1, ~exp_addr};
    @(posedge REF_CLK);
    START <= 1'b0;
    i = 0;
    while (DONE !== 1'b1 && i < 3000) begin
      @(negedge REF_CLK);
      i++;
    end
    `CHK(i < 3000, 1'b1)
    `CHK(RESULT, r)
    `CHK(n_rd, rd)
    `CHK(n_wr, wr)
    `CHK(LAST_STAT.timing_failure_flag, f)
    `CHK(WIN_LATE, wc & w)
    `CHK(LAST_STAT.erase_window_bit, w)
    `CHK(LAST_STAT.poll_status_bit, (r == RES_DONE) ? mdata[7] : ~mdata[7])
    @(posedge REF_CLK);
    {arm, ABORT} <= 2'b00;
  endtask

  task automatic give_verdict();
    if (n_errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // watchdog sized well beyond the longest expected job list
  initial begin
    repeat (40000) @(posedge REF_CLK);
    n_errors++;
    give_verdict();
  end

  initial begin
    void'($urandom(53));
    repeat (10) @(posedge REF_CLK);
    @(negedge REF_CLK);
    `CHK({CE_N, OE_N, WE_N, DQ_OE_N, BUSY, DONE}, 6'h3C)
    @(posedge REF_CLK);
    RESET <= 1'b0;
    job(0, 1'b0, 1'b0, 1'b0, 1'b0); // already finished
    job(255, 1'b1, 1'b0, 1'b0, 1'b0); // failure flag and still toggling
    job(2, 1'b1, 1'b0, 1'b0, 1'b0); // failure flag but stopped on recheck
    job(5, 1'b0, 1'b1, 1'b0, 1'b0); // toggle stops, polling bit incomplete
    job(255, 1'b0, 1'b0, 1'b1, 1'b0); // host leaves polling
    job(3, 1'b0, 1'b0, 1'b0, 1'b1); // erase window already closed
    for (int k = 0; k < 12; k++) job($urandom_range(1, 9), 1'b0, 1'b0, 1'b0, 1'($urandom));
    give_verdict();
  end
endmodule
